// File: logic/cdsf_defs.vh
/*
 Constants of the channel diagnostic status block: channel count,
 status codes, register offsets and layouts, reset values, timings.
 Assumes a 250 MHz core clock and a 32-bit APB with byte addresses.
*/
// How it works
// - Supply short holds code 001 until read
// - Code 010 leaves only on supply short/read
// - Code 011 yields to either short or read
// - Both checks clean give 100; faults replace
// - Missing clean check promotes 101/110 to 100
// - From 111, clean on-check enabled gives 101
// - From 111, clean off-check gives 110 if ok
// - From 111, enabled supply short gives 001
// - From 111, ground short gives 010 if ok
// - From 111, open load gives 011 if ok
// - Status read returns code then sets 111
// - Power-on or external reset force 111
// - Supply recovery restarts off-check for off channels
// - On-check starts on three enable/command cases
// - Off-check starts on disable/command fall cases
// - Check completes only after uninterrupted timers
// - Core disabled unless all supplies valid
// - Output disable never alters stored codes
// - Read in undervoltage keeps 111 while off
`ifndef CDSF_DEFS_VH
`define CDSF_DEFS_VH

`define CDSF_NCH 6

`define CDSF_ST_SCB 3'h1
`define CDSF_ST_SCG 3'h2
`define CDSF_ST_OLF 3'h3
`define CDSF_ST_DONE 3'h4
`define CDSF_ST_ON_OK 3'h5
`define CDSF_ST_OFF_OK 3'h6
`define CDSF_ST_NONE 3'h7

`define CDSF_OFS_CTRL 12'h000
`define CDSF_OFS_STATUS 12'h004
`define CDSF_OFS_PULSE 12'h008
`define CDSF_OFS_SUPPLY 12'h00C
`define CDSF_OFS_BUSY 12'h010

`define CDSF_PULSE_ON_LSB 0
`define CDSF_PULSE_OFF_LSB 8
`define CDSF_CTRL_RST 6'h00

`define CDSF_CLK_PERIOD_NS 4
`define CDSF_BLANK_ON_NS 2000
`define CDSF_BLANK_OFF_NS 2000
`define CDSF_FILTER_NS 1000
`define CDSF_CYC(ns) (((ns) + `CDSF_CLK_PERIOD_NS - 1) / `CDSF_CLK_PERIOD_NS)

`endif

// File: logic/cdsf_chan.v
/*
 One channel's check timer and status state machine.
 Assumes all inputs are synchronous to clk_i and already filtered
 of metastability; start and read-clear inputs are one-cycle pulses, soft clear is a level.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cdsf_defs.vh"
module cdsf_chan (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire soft_clr_i,
    // Conditions and triggers
    input wire dis_i,
    input wire uv_i,
    input wire start_on_i,
    input wire start_off_i,
    input wire rd_clr_i,
    // Fault comparators
    input wire scb_i,
    input wire scg_i,
    input wire olf_i,
    // State
    output wire [2:0] code_o,
    output wire busy_o
);
    localparam [1:0] M_IDLE = 2'b00;
    localparam [1:0] M_ON = 2'b01;
    localparam [1:0] M_OFF = 2'b10;
    localparam [11:0] BL_ON = `CDSF_CYC(`CDSF_BLANK_ON_NS) - 1;
    localparam [11:0] BL_OFF = `CDSF_CYC(`CDSF_BLANK_OFF_NS) - 1;
    localparam [11:0] FLT = `CDSF_CYC(`CDSF_FILTER_NS) - 1;

    reg [1:0] mode_q;
    reg [11:0] cnt_q;
    reg [2:0] flt_q;
    reg [2:0] code_q;
    reg [2:0] code_d;
    reg [2:0] base;
    wire [2:0] flt_now;
    wire abort;
    wire done;
    wire on_end;
    wire off_end;

    assign flt_now = (mode_q == M_ON) ? {scb_i, 2'b00} : {1'b0, scg_i, olf_i};
    // Leaving enable or losing the core cuts a check short
    assign abort = soft_clr_i | dis_i | ((mode_q == M_OFF) & uv_i);
    assign done = (mode_q != M_IDLE) & ~abort & ~start_on_i & ~start_off_i
        & (cnt_q == 12'h000) & (flt_now == flt_q);
    assign on_end = done & (mode_q == M_ON);
    assign off_end = done & (mode_q == M_OFF);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= M_IDLE;
            cnt_q <= 12'h000;
            flt_q <= 3'h0;
        end else if (abort) begin
            mode_q <= M_IDLE;
        end else if (start_on_i) begin
            mode_q <= M_ON;
            cnt_q <= BL_ON;
            flt_q <= {scb_i, 2'b00};
        end else if (start_off_i) begin
            mode_q <= M_OFF;
            cnt_q <= BL_OFF;
            flt_q <= {1'b0, scg_i, olf_i};
        end else if (mode_q != M_IDLE) begin
            // A comparator change restarts the filter time
            if (flt_now != flt_q) begin
                cnt_q <= FLT;
                flt_q <= flt_now;
            end else if (cnt_q == 12'h000) begin
                mode_q <= M_IDLE;
            end else begin
                cnt_q <= cnt_q - 12'h001;
            end
        end
    end

    // A read lands first so a same-cycle result is not lost
    always @* begin
        base = rd_clr_i ? `CDSF_ST_NONE : code_q;
        code_d = base;
        case (base)
            `CDSF_ST_SCB: code_d = base;
            `CDSF_ST_SCG: begin
                if (on_end & scb_i) code_d = `CDSF_ST_SCB;
            end
            `CDSF_ST_OLF: begin
                if (on_end & scb_i) code_d = `CDSF_ST_SCB;
                else if (off_end & scg_i) code_d = `CDSF_ST_SCG;
            end
            `CDSF_ST_DONE, `CDSF_ST_ON_OK, `CDSF_ST_OFF_OK: begin
                if (on_end & scb_i) code_d = `CDSF_ST_SCB;
                else if (off_end & scg_i) code_d = `CDSF_ST_SCG;
                else if (off_end & olf_i) code_d = `CDSF_ST_OLF;
                else if (off_end & (base == `CDSF_ST_ON_OK))
                    code_d = `CDSF_ST_DONE;
                else if (on_end & (base == `CDSF_ST_OFF_OK))
                    code_d = `CDSF_ST_DONE;
            end
            default: begin
                if (on_end & ~dis_i & scb_i)
                    code_d = `CDSF_ST_SCB;
                else if (on_end & ~dis_i)
                    code_d = `CDSF_ST_ON_OK;
                else if (off_end & ~dis_i & ~uv_i & scg_i)
                    code_d = `CDSF_ST_SCG;
                else if (off_end & ~dis_i & ~uv_i & olf_i)
                    code_d = `CDSF_ST_OLF;
                else if (off_end & ~dis_i & ~uv_i)
                    code_d = `CDSF_ST_OFF_OK;
            end
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_q <= `CDSF_ST_NONE;
        end else if (soft_clr_i) begin
            code_q <= `CDSF_ST_NONE;
        end else begin
            code_q <= code_d;
        end
    end

    assign code_o = code_q;
    assign busy_o = (mode_q != M_IDLE);
endmodule
`default_nettype wire

// File: logic/cdsf_top.v
/*
 Six-channel diagnostic status block with an APB register slave.
 Assumes pins arrive asynchronously and pass two flip-flops here;
 the APB master runs on CORE_CLK_I.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cdsf_defs.vh"
module cdsf_top (
    // Clock and reset
    input wire CORE_CLK_I,
    input wire SYS_RST_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    // Device pins
    input wire OUTPUT_DISABLE_IN_I,
    input wire EXT_RESET_LOW_N_I,
    input wire [5:0] PARALLEL_DRIVE_IN_I,
    // Supply monitors
    input wire LOAD_SUPPLY_OK_I,
    input wire LOAD_UNDERVOLT_LEVEL_I,
    input wire INTERFACE_SUPPLY_OK_I,
    input wire FAULT_REFERENCE_OK_I,
    // Drain comparators
    input wire [5:0] SHORT_TO_SUPPLY_I,
    input wire [5:0] SHORT_TO_GROUND_I,
    input wire [5:0] OPEN_LOAD_I,
    // Status
    output wire [17:0] CHANNEL_STATUS_CODE_O,
    output wire CORE_ENABLED_O
);
    localparam PW = 30;

    // Two-stage synchroniser for every pin
    reg [PW-1:0] pin_s1_q;
    reg [PW-1:0] pin_s2_q;
    wire [PW-1:0] pin_raw;

    wire dis;
    wire ext_rst_n;
    wire load_ok;
    wire uv;
    wire if_ok;
    wire fref_ok;
    wire [5:0] par_in;
    wire [5:0] short_to_supply;
    wire [5:0] short_to_ground;
    wire [5:0] open_load;

    // Edge history
    reg dis_prev_q;
    reg uv_prev_q;
    reg [5:0] par_prev_q;
    reg [5:0] gate_prev_q;

    // Software state
    reg [5:0] gate_q;
    reg [5:0] on_pulse_q;
    reg [5:0] off_pulse_q;
    reg rd_clr_q;
    reg core_en_q;

    // Bus state
    reg pready_q;
    reg pslverr_q;
    reg [31:0] prdata_q;
    wire setup_ack;
    wire xfer_done;
    wire wr_done;
    wire rd_done;

    // Channel wiring
    wire core_en;
    wire soft_clr;
    wire [5:0] cmd;
    wire [5:0] cmd_prev;
    wire [5:0] start_on;
    wire [5:0] start_off;
    wire [17:0] codes;
    wire [5:0] busy;

    assign pin_raw = {OUTPUT_DISABLE_IN_I, EXT_RESET_LOW_N_I,
        LOAD_SUPPLY_OK_I, LOAD_UNDERVOLT_LEVEL_I,
        INTERFACE_SUPPLY_OK_I, FAULT_REFERENCE_OK_I,
        PARALLEL_DRIVE_IN_I, SHORT_TO_SUPPLY_I,
        SHORT_TO_GROUND_I, OPEN_LOAD_I};

    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pin_s1_q <= {PW{1'b0}};
            pin_s2_q <= {PW{1'b0}};
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign dis = pin_s2_q[29];
    assign ext_rst_n = pin_s2_q[28];
    assign load_ok = pin_s2_q[27];
    assign uv = pin_s2_q[26];
    assign if_ok = pin_s2_q[25];
    assign fref_ok = pin_s2_q[24];
    assign par_in = pin_s2_q[23:18];
    assign short_to_supply = pin_s2_q[17:12];
    assign short_to_ground = pin_s2_q[11:6];
    assign open_load = pin_s2_q[5:0];

    // Register decode
    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = hit(addr, `CDSF_OFS_CTRL)
                | hit(addr, `CDSF_OFS_STATUS)
                | hit(addr, `CDSF_OFS_PULSE)
                | hit(addr, `CDSF_OFS_SUPPLY)
                | hit(addr, `CDSF_OFS_BUSY);
        end
    endfunction

    function [31:0] rd_mux;
        input [11:0] addr;
        input [5:0] g;
        input [17:0] c;
        input [5:0] sup;
        input [5:0] b;
        begin
            rd_mux = 32'h0000_0000;
            if (hit(addr, `CDSF_OFS_CTRL))
                rd_mux = {26'h000_0000, g};
            else if (hit(addr, `CDSF_OFS_STATUS))
                rd_mux = {14'h0000, c};
            else if (hit(addr, `CDSF_OFS_SUPPLY))
                rd_mux = {26'h000_0000, sup};
            else if (hit(addr, `CDSF_OFS_BUSY))
                rd_mux = {26'h000_0000, b};
        end
    endfunction

    // One wait state: pready rises in the second access cycle
    assign setup_ack = PSEL_I & PENABLE_I & ~pready_q;
    assign xfer_done = PSEL_I & PENABLE_I & pready_q;
    assign wr_done = xfer_done & PWRITE_I & mapped(PADDR_I);
    assign rd_done = xfer_done & ~PWRITE_I;

    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_ack;
            if (setup_ack) begin
                pslverr_q <= ~mapped(PADDR_I);
                // Code is sampled here, before the read clears it
                prdata_q <= PWRITE_I ? 32'h0000_0000 :
                    rd_mux(PADDR_I, gate_q, codes,
                    {core_en, if_ok, fref_ok, load_ok, uv, ext_rst_n},
                    busy);
            end else begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // Software gate commands and pulse requests
    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            gate_q <= `CDSF_CTRL_RST;
            on_pulse_q <= 6'h00;
            off_pulse_q <= 6'h00;
            rd_clr_q <= 1'b0;
        end else begin
            on_pulse_q <= 6'h00;
            off_pulse_q <= 6'h00;
            rd_clr_q <= rd_done & hit(PADDR_I, `CDSF_OFS_STATUS);
            if (soft_clr) begin
                gate_q <= `CDSF_CTRL_RST;
            end else if (wr_done & hit(PADDR_I, `CDSF_OFS_CTRL)) begin
                gate_q <= PWDATA_I[5:0];
            end else if (wr_done & hit(PADDR_I, `CDSF_OFS_PULSE)) begin
                on_pulse_q <= PWDATA_I[`CDSF_PULSE_ON_LSB +: 6];
                off_pulse_q <= PWDATA_I[`CDSF_PULSE_OFF_LSB +: 6];
            end
        end
    end

    // Edge history follows the synchronised levels
    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            dis_prev_q <= 1'b1;
            uv_prev_q <= 1'b0;
            par_prev_q <= 6'h00;
            gate_prev_q <= 6'h00;
            core_en_q <= 1'b0;
        end else begin
            dis_prev_q <= dis;
            uv_prev_q <= uv;
            par_prev_q <= par_in;
            gate_prev_q <= gate_q;
            core_en_q <= core_en;
        end
    end

    // Core runs only with every supply valid
    assign core_en = if_ok & load_ok & fref_ok;
    assign soft_clr = ~core_en | ~ext_rst_n;

    assign cmd = par_in | gate_q;
    assign cmd_prev = par_prev_q | gate_prev_q;

    // Disable falling, a command rising, or a pulse request
    assign start_on = ({6{dis_prev_q & ~dis}} & cmd)
        | ({6{~dis}} & cmd & ~cmd_prev)
        | ({6{~dis}} & on_pulse_q);

    // Off-state starts; supply recovery retriggers idle-low channels
    assign start_off = ({6{dis_prev_q & ~dis}} & ~cmd)
        | ({6{~dis}} & ~cmd & cmd_prev)
        | ({6{~dis}} & off_pulse_q)
        | ({6{~dis & uv_prev_q & ~uv}} & ~cmd);

    // Output disable only aborts checks; codes stay put
    genvar i;
    generate
        for (i = 0; i < `CDSF_NCH; i = i + 1) begin : g_ch
            cdsf_chan u_chan (
                .clk_i(CORE_CLK_I),
                .rst_i(SYS_RST_I),
                .soft_clr_i(soft_clr),
                .dis_i(dis),
                .uv_i(uv),
                .start_on_i(start_on[i]),
                .start_off_i(start_off[i]),
                .rd_clr_i(rd_clr_q),
                .scb_i(short_to_supply[i]),
                .scg_i(short_to_ground[i]),
                .olf_i(open_load[i]),
                .code_o(codes[3*i +: 3]),
                .busy_o(busy[i])
            );
        end
    endgenerate

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign CHANNEL_STATUS_CODE_O = codes;
    assign CORE_ENABLED_O = core_en_q;
endmodule
`default_nettype wire

// File: bench/cdsf_properties.sv
/*
 Port checker for the diagnostic status block.
 Assumes one core clock and an active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module cdsf_props (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    // APB
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // Pins and state
    input wire logic OUTPUT_DISABLE_IN_I,
    input wire logic EXT_RESET_LOW_N_I,
    input wire logic LOAD_SUPPLY_OK_I,
    input wire logic [17:0] CHANNEL_STATUS_CODE_O,
    input wire logic CORE_ENABLED_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire logic [2:0] c1 = CHANNEL_STATUS_CODE_O[5:3];
    wire logic [2:0] c2 = CHANNEL_STATUS_CODE_O[8:6];
    wire logic [2:0] c3 = CHANNEL_STATUS_CODE_O[11:9];
    sequence setup_s; PSEL_I && !PENABLE_I; endsequence
    sequence access_s; PSEL_I && PENABLE_I; endsequence
    AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !PREADY_O ##1 PREADY_O)
        else $error("ready not in second access cycle");
    AST_READY_ACCESS: assert property (PREADY_O |->
        PSEL_I && PENABLE_I && $past(PENABLE_I)) else $error("stray ready");
    AST_UNMAPPED: assert property (PREADY_O && PADDR_I > 12'h010 |->
        PSLVERR_O && PRDATA_O == 32'h0000_0000) else $error("unmapped answer");
    AST_READ_VALUE: assert property (PREADY_O && !PWRITE_I && PADDR_I == 12'h004
        |-> PRDATA_O == {14'h0000, $past(CHANNEL_STATUS_CODE_O)})
        else $error("status read value");
    AST_SCB_HOLD: assert property ($past(c1) == 3'h1 && c1 != 3'h1 |->
        c1 == 3'h7) else $error("supply short code left wrongly");
    AST_SCG_EXIT: assert property ($past(c2) == 3'h2 && c2 != 3'h2 |->
        c2 == 3'h1 || c2 == 3'h7) else $error("ground short code left wrongly");
    AST_OLF_EXIT: assert property ($past(c3) == 3'h3 && c3 != 3'h3 |->
        c3 inside {3'h1, 3'h2, 3'h7}) else $error("open load code left wrongly");
    AST_EXT_RESET: assert property (!EXT_RESET_LOW_N_I [*5] |->
        CHANNEL_STATUS_CODE_O == 18'h3_ffff) else $error("ext reset codes");
    AST_CORE_OFF: assert property (!LOAD_SUPPLY_OK_I [*5] |->
        !CORE_ENABLED_O && CHANNEL_STATUS_CODE_O == 18'h3_ffff)
        else $error("core not disabled");
    AST_DISABLE_KEEPS: assert property ((OUTPUT_DISABLE_IN_I && !PSEL_I &&
        CORE_ENABLED_O && EXT_RESET_LOW_N_I) [*4] |->
        $stable(CHANNEL_STATUS_CODE_O)) else $error("disable changed codes");
endmodule
bind cdsf_top cdsf_props u_props (.*);
`default_nettype wire

// File: bench/cdsf_mcu.sv
/*
 APB master standing in for the controller.
 Assumes it shares the core clock with the slave.
*/
`timescale 1ns/1ns
`default_nettype none
module cdsf_mcu (
    // Clock
    input wire logic clk_i,
    // Request
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    // Answer
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0000_0000;
    end
    // Whole aligned words only, so every request is a complete frame
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!pready_i && n < 64);
        q = prdata_i;
        e = pslverr_i;
        // A missing answer must fail the caller's compare
        if (!pready_i) begin
            q = 32'hxxxx_xxxx;
            e = 1'bx;
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released data must not look like the last word
        pwdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// File: bench/cdsf_top_bench.sv
/*
 Directed bench for the diagnostic status block.
 Assumes a 500-cycle blanking time, so a check settles in 520 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module cdsf_top_bench;
    logic clk, rst, dis, ext_n, uv, ld_ok, e;
    logic [5:0] par, short_to_supply, short_to_ground, open_load;
    logic [31:0] q;
    wire logic psel, pen, pwr, pready, pslverr, core_en;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [17:0] codes;
    int err_count, n_checks;
    cdsf_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .OUTPUT_DISABLE_IN_I(dis), .EXT_RESET_LOW_N_I(ext_n),
        .PARALLEL_DRIVE_IN_I(par), .LOAD_SUPPLY_OK_I(ld_ok),
        .LOAD_UNDERVOLT_LEVEL_I(uv), .INTERFACE_SUPPLY_OK_I(1'b1),
        .FAULT_REFERENCE_OK_I(1'b1), .SHORT_TO_SUPPLY_I(short_to_supply),
        .SHORT_TO_GROUND_I(short_to_ground), .OPEN_LOAD_I(open_load),
        .CHANNEL_STATUS_CODE_O(codes), .CORE_ENABLED_O(core_en));
    cdsf_mcu u_mcu (.clk_i(clk), .psel_o(psel), .penable_o(pen),
        .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata),
        .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
    function automatic [31:0] c6(input [2:0] a, b, c, d, f, g);
        c6 = {14'h0000, a, b, c, d, f, g};
    endfunction
    task automatic ck(input string n, input logic [31:0] x, g);
        n_checks++;
        if (g !== x) begin
            $display("BAD %s exp %h got %h", n, x, g);
            err_count++;
        end
    endtask
    task automatic cc(input string n, input logic [31:0] x);
        ck(n, x, {14'h0000, codes});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_mcu.xfer(1'b1, a, d, q, e);
        ck("write error", 32'h0000_0000, {31'h0000_0000, e});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        u_mcu.xfer(1'b0, a, 32'h0000_0000, q, e);
        ck("read data", x, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        cyc(20000);
        err_count++;
        report_and_stop;
    end
    initial begin
        rst = 1'b1; dis = 1'b0; ext_n = 1'b1; uv = 1'b0; ld_ok = 1'b1;
        par = 6'h00; short_to_supply = 6'h02; short_to_ground = 6'h04; open_load = 6'h08;
        cyc(6);
        rst <= 1'b0;
        cyc(4);
        cc("reset codes", 32'h0003_ffff);
        u_mcu.xfer(1'b0, 12'h014, 32'h0000_0000, q, e);
        ck("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
        ck("unmapped data", 32'h0000_0000, q);
        rd(12'h00c, 32'h0000_003d);
        // Four channels by gate command, one by parallel input, one idle
        wr(12'h000, 32'h0000_000f);
        par <= 6'h10;
        rd(12'h000, 32'h0000_000f);
        rd(12'h010, 32'h0000_001f);
        cyc(520);
        cc("on check", c6(3'h7, 3'h5, 3'h5, 3'h5, 3'h1, 3'h5));
        wr(12'h000, 32'h0000_0000);
        par <= 6'h00;
        cyc(520);
        cc("off check", c6(3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h4));
        rd(12'h004, c6(3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h4));
        cyc(3);
        cc("read clear", 32'h0003_ffff);
        wr(12'h008, 32'h0000_3f00);
        cyc(520);
        cc("off pulse", c6(3'h6, 3'h6, 3'h3, 3'h2, 3'h6, 3'h6));
        uv <= 1'b1;
        cyc(4);
        rd(12'h004, c6(3'h6, 3'h6, 3'h3, 3'h2, 3'h6, 3'h6));
        wr(12'h008, 32'h0000_3f00);
        cyc(520);
        rd(12'h004, 32'h0003_ffff);
        uv <= 1'b0;
        cyc(524);
        cc("uv end", c6(3'h6, 3'h6, 3'h3, 3'h2, 3'h6, 3'h6));
        short_to_supply <= 6'h0e;
        wr(12'h008, 32'h0000_003f);
        cyc(520);
        cc("on pulse", c6(3'h4, 3'h4, 3'h1, 3'h1, 3'h1, 3'h4));
        dis <= 1'b1;
        cyc(30);
        cc("disable", c6(3'h4, 3'h4, 3'h1, 3'h1, 3'h1, 3'h4));
        ext_n <= 1'b0;
        cyc(8);
        cc("ext reset", 32'h0003_ffff);
        ext_n <= 1'b1;
        dis <= 1'b0;
        ld_ok <= 1'b0;
        cyc(8);
        ck("core off", 32'h0000_0000, {31'h0000_0000, core_en});
        ld_ok <= 1'b1;
        cyc(8);
        ck("core on", 32'h0000_0001, {31'h0000_0000, core_en});
        report_and_stop;
    end
endmodule
`default_nettype wire
